// ===== hdl/abex_pkg.sv
/*
 * abex_pkg: operation codes, flag positions, cycle counts and widths for the
 * arithmetic, logic, compare, skip and branch execute block.
 * assumes: a decoder upstream presents one operation at a time.
 */
package abex_pkg;
    localparam int DW = 8;
    localparam int PCW = 16;
    localparam int OFSW = 12;
    // status flag bit positions
    localparam int FL_C = 0;
    localparam int FL_Z = 1;
    localparam int FL_N = 2;
    localparam int FL_V = 3;
    localparam int FL_S = 4;
    localparam int FL_H = 5;
    localparam int FL_T = 6;
    localparam int FL_I = 7;
    localparam logic [7:0] ALL_ONES = 8'hff;
    localparam logic [2:0] CYC_ONE = 3'h1;
    localparam logic [2:0] CYC_TWO = 3'h2;
    localparam logic [2:0] CYC_THREE = 3'h3;
    localparam logic [2:0] CYC_FOUR = 3'h4;
    localparam logic [PCW-1:0] PC_STEP = 16'h0001;
    localparam logic [PCW-1:0] PC_SKIP1 = 16'h0002;
    localparam logic [PCW-1:0] PC_SKIP2 = 16'h0003;

    typedef enum logic [5:0] {
        OP_NOP, OP_ADD, OP_ADC, OP_ADD_WORD_IMM, OP_SUB, OP_DIFF_IMM, OP_DIFF_BORROW,
        OP_DIFF_IMM_BORROW, OP_WORD_MINUS_IMM, OP_AND, OP_AND_IMM, OP_OR, OP_OR_IMM,
        OP_XOR_REGS, OP_ONES_INVERT, OP_TWOS_COMPLEMENT, OP_SET_BITS_MASK,
        OP_CLEAR_BITS_MASK, OP_INC, OP_DEC, OP_ZERO_MINUS_TEST, OP_ZERO_REGISTER,
        OP_SET_ALL_ONES, OP_REL_JUMP, OP_IND_JUMP, OP_REL_CALL, OP_IND_CALL,
        OP_ROUTINE_EXIT, OP_IRQ_EXIT, OP_SKIP_IF_EQUAL, OP_CMP_REGS, OP_CMP_BORROW,
        OP_CMP_IMM, OP_SKIP_REG_CLR, OP_SKIP_REG_SET, OP_SKIP_IO_CLR, OP_SKIP_IO_SET,
        OP_BRANCH_SET, OP_BRANCH_CLR
    } abex_op_t;

    typedef enum logic [1:0] {
        ST_IDLE, ST_BUSY
    } abex_state_t;
endpackage

// ===== hdl/abex_core.sv
/*
 * abex_core: executes one arithmetic, logic, compare, skip, jump, call,
 * return or conditional branch per request and reports result, flags, the
 * next program counter and the cycle cost by holding busy.
 * assumes: the register file, status register and stack sit outside; operands
 * are stable while op_valid is high and the core is idle.
 */
`timescale 1ns/1ps

module abex_core
    import abex_pkg::*;
(
    input  wire logic            ref_clk,
    input  wire logic            rst,
    input  wire logic            op_valid,
    input  wire abex_op_t        op_code,
    input  wire logic [DW-1:0]   opnd_d,
    input  wire logic [DW-1:0]   opnd_d_high,
    input  wire logic [DW-1:0]   opnd_r,
    input  wire logic [2:0]      bit_sel,
    input  wire logic [DW-1:0]   io_value,
    input  wire logic [OFSW-1:0] pc_offset,
    input  wire logic [PCW-1:0]  pc_now,
    input  wire logic [PCW-1:0]  z_pointer,
    input  wire logic [PCW-1:0]  stack_pc,
    input  wire logic            next_is_long,
    input  wire logic [7:0]      flags_in,
    output logic                 op_ready,
    output logic                 done,
    output logic [DW-1:0]        result_lo,
    output logic [DW-1:0]        result_hi,
    output logic                 write_lo,
    output logic                 write_hi,
    output logic [7:0]           flags_out,
    output logic [PCW-1:0]       pc_next,
    output logic                 push_pc,
    output logic [2:0]           cycles
);

    typedef struct packed {
        abex_state_t    state;
        logic [2:0]     left;
        logic           done;
        logic [DW-1:0]  result_lo;
        logic [DW-1:0]  result_hi;
        logic           write_lo;
        logic           write_hi;
        logic [7:0]     flags;
        logic [PCW-1:0] pc_next;
        logic           push_pc;
        logic [2:0]     cycles;
    } abex_regs_t;

    abex_regs_t cur;
    abex_regs_t next_cur;

    // combinational datapath results
    logic [DW:0]     sum9;
    logic [DW-1:0]   a_val;
    logic [DW-1:0]   b_val;
    logic            cin;
    logic            is_sub;
    logic [DW-1:0]   res8;
    logic            hc;
    logic            c8;
    logic            v8;
    logic [PCW-1:0]  word_in;
    logic [PCW:0]    word17;
    logic [PCW-1:0]  word_res;
    logic [PCW-1:0]  pc_rel;
    logic [PCW-1:0]  pc_seq;
    logic            cond;
    logic            flag_val;

    always_comb begin
        a_val = opnd_d;
        b_val = opnd_r;
        cin = 1'b0;
        is_sub = 1'b0;
        case (op_code)
            OP_ADC: begin
                cin = flags_in[FL_C];
            end
            OP_SUB, OP_DIFF_IMM, OP_CMP_REGS, OP_CMP_IMM: begin
                is_sub = 1'b1;
            end
            OP_DIFF_BORROW, OP_DIFF_IMM_BORROW, OP_CMP_BORROW: begin
                is_sub = 1'b1;
                cin = flags_in[FL_C];
            end
            OP_TWOS_COMPLEMENT: begin
                a_val = '0;
                b_val = opnd_d;
                is_sub = 1'b1;
            end
            default: begin
                cin = 1'b0;
            end
        endcase
        if (is_sub) begin
            sum9 = {1'b0, a_val} - {1'b0, b_val} - {{DW{1'b0}}, cin};
        end else begin
            sum9 = {1'b0, a_val} + {1'b0, b_val} + {{DW{1'b0}}, cin};
        end
        res8 = sum9[DW-1:0];
        c8 = sum9[DW];
        if (is_sub) begin
            hc = (~a_val[3] & b_val[3]) | (b_val[3] & res8[3]) | (res8[3] & ~a_val[3]);
            v8 = (a_val[7] & ~b_val[7] & ~res8[7]) | (~a_val[7] & b_val[7] & res8[7]);
        end else begin
            hc = (a_val[3] & b_val[3]) | (b_val[3] & ~res8[3]) | (~res8[3] & a_val[3]);
            v8 = (a_val[7] & b_val[7] & ~res8[7]) | (~a_val[7] & ~b_val[7] & res8[7]);
        end
    end

    // word operand: high byte over low byte, immediate in opnd_r
    assign word_in = {opnd_d_high, opnd_d};
    assign word17 = (op_code == OP_WORD_MINUS_IMM)
                  ? ({1'b0, word_in} - {{(PCW+1-DW){1'b0}}, opnd_r})
                  : ({1'b0, word_in} + {{(PCW+1-DW){1'b0}}, opnd_r});
    assign word_res = word17[PCW-1:0];
    assign pc_rel = pc_now + {{(PCW-OFSW){pc_offset[OFSW-1]}}, pc_offset} + PC_STEP;
    assign pc_seq = pc_now + PC_STEP;

    always_comb begin
        case (bit_sel)
            3'h0: flag_val = flags_in[FL_C];
            3'h1: flag_val = flags_in[FL_Z];
            3'h2: flag_val = flags_in[FL_N];
            3'h3: flag_val = flags_in[FL_V];
            3'h4: flag_val = flags_in[FL_S];
            3'h5: flag_val = flags_in[FL_H];
            3'h6: flag_val = flags_in[FL_T];
            default: flag_val = flags_in[FL_I];
        endcase
    end

    always_comb begin
        next_cur = cur;
        next_cur.done = 1'b0;
        next_cur.write_lo = 1'b0;
        next_cur.write_hi = 1'b0;
        next_cur.push_pc = 1'b0;
        cond = 1'b0;
        case (cur.state)
            ST_IDLE: begin
                if (op_valid) begin
                    next_cur.flags = flags_in;
                    next_cur.pc_next = pc_seq;
                    next_cur.cycles = CYC_ONE;
                    next_cur.result_lo = res8;
                    next_cur.result_hi = opnd_d_high;
                    case (op_code)
                        OP_ADD, OP_ADC, OP_SUB, OP_DIFF_IMM, OP_DIFF_BORROW,
                        OP_DIFF_IMM_BORROW, OP_TWOS_COMPLEMENT: begin
                            next_cur.write_lo = 1'b1;
                            next_cur.flags[FL_Z] = (res8 == '0);
                            next_cur.flags[FL_C] = c8;
                            next_cur.flags[FL_N] = res8[7];
                            next_cur.flags[FL_V] = v8;
                            next_cur.flags[FL_H] = hc;
                            next_cur.flags[FL_S] = res8[7] ^ v8;
                        end
                        OP_CMP_REGS, OP_CMP_BORROW, OP_CMP_IMM: begin
                            next_cur.flags[FL_Z] = (res8 == '0);
                            next_cur.flags[FL_C] = c8;
                            next_cur.flags[FL_N] = res8[7];
                            next_cur.flags[FL_V] = v8;
                            next_cur.flags[FL_H] = hc;
                            next_cur.flags[FL_S] = res8[7] ^ v8;
                        end
                        OP_ADD_WORD_IMM, OP_WORD_MINUS_IMM: begin
                            next_cur.result_lo = word_res[DW-1:0];
                            next_cur.result_hi = word_res[PCW-1:DW];
                            next_cur.write_lo = 1'b1;
                            next_cur.write_hi = 1'b1;
                            next_cur.flags[FL_Z] = (word_res == '0);
                            next_cur.flags[FL_C] = word17[PCW];
                            next_cur.flags[FL_N] = word_res[PCW-1];
                            next_cur.flags[FL_V] = (op_code == OP_ADD_WORD_IMM)
                                ? (~opnd_d_high[7] & word_res[PCW-1])
                                : (opnd_d_high[7] & ~word_res[PCW-1]);
                            next_cur.flags[FL_S] = word_res[PCW-1] ^ next_cur.flags[FL_V];
                            next_cur.cycles = CYC_TWO;
                        end
                        default: begin
                            next_cur.cycles = CYC_ONE;
                        end
                    endcase
                    // logic ops, mask ops, unary ops: Z N V only; ones invert also sets C, set all ones leaves the flags
                    case (op_code)
                        OP_AND, OP_AND_IMM: next_cur.result_lo = opnd_d & opnd_r;
                        // test ands the register with itself, the source port is not used
                        OP_ZERO_MINUS_TEST: next_cur.result_lo = opnd_d & opnd_d;
                        OP_OR, OP_OR_IMM, OP_SET_BITS_MASK: next_cur.result_lo = opnd_d | opnd_r;
                        OP_CLEAR_BITS_MASK: next_cur.result_lo = opnd_d & (ALL_ONES ^ opnd_r);
                        OP_XOR_REGS: next_cur.result_lo = opnd_d ^ opnd_r;
                        OP_ZERO_REGISTER: next_cur.result_lo = opnd_d ^ opnd_d;
                        OP_INC: next_cur.result_lo = opnd_d + 8'h01;
                        OP_DEC: next_cur.result_lo = opnd_d - 8'h01;
                        OP_ONES_INVERT: next_cur.result_lo = ALL_ONES - opnd_d;
                        OP_SET_ALL_ONES: next_cur.result_lo = ALL_ONES;
                        default: next_cur.result_lo = next_cur.result_lo;
                    endcase
                    case (op_code)
                        OP_AND, OP_AND_IMM, OP_ZERO_MINUS_TEST, OP_OR, OP_OR_IMM,
                        OP_SET_BITS_MASK, OP_CLEAR_BITS_MASK, OP_XOR_REGS,
                        OP_ZERO_REGISTER, OP_INC, OP_DEC, OP_ONES_INVERT: begin
                            next_cur.write_lo = 1'b1;
                            next_cur.flags[FL_Z] = (next_cur.result_lo == '0);
                            next_cur.flags[FL_N] = next_cur.result_lo[7];
                            next_cur.flags[FL_V] = 1'b0;
                            if (op_code == OP_INC) begin
                                next_cur.flags[FL_V] = (opnd_d == 8'h7f);
                            end
                            if (op_code == OP_DEC) begin
                                next_cur.flags[FL_V] = (opnd_d == 8'h80);
                            end
                            if (op_code == OP_ONES_INVERT) begin
                                next_cur.flags[FL_C] = 1'b1;
                            end
                        end
                        OP_SET_ALL_ONES: begin
                            next_cur.write_lo = 1'b1;
                        end
                        default: begin
                            next_cur.write_lo = next_cur.write_lo;
                        end
                    endcase
                    case (op_code)
                        OP_SKIP_IF_EQUAL: cond = (opnd_d == opnd_r);
                        OP_SKIP_REG_CLR: cond = ~opnd_r[bit_sel];
                        OP_SKIP_REG_SET: cond = opnd_r[bit_sel];
                        OP_SKIP_IO_CLR: cond = ~io_value[bit_sel];
                        OP_SKIP_IO_SET: cond = io_value[bit_sel];
                        OP_BRANCH_SET: cond = flag_val;
                        OP_BRANCH_CLR: cond = ~flag_val;
                        default: cond = 1'b0;
                    endcase
                    case (op_code)
                        OP_SKIP_IF_EQUAL, OP_SKIP_REG_CLR, OP_SKIP_REG_SET,
                        OP_SKIP_IO_CLR, OP_SKIP_IO_SET: begin
                            if (cond) begin
                                next_cur.pc_next = pc_now + (next_is_long ? PC_SKIP2 : PC_SKIP1);
                                next_cur.cycles = next_is_long ? CYC_THREE : CYC_TWO;
                            end
                        end
                        OP_BRANCH_SET, OP_BRANCH_CLR: begin
                            if (cond) begin
                                next_cur.pc_next = pc_rel;
                                next_cur.cycles = CYC_TWO;
                            end
                        end
                        OP_REL_JUMP: begin
                            next_cur.pc_next = pc_rel;
                            next_cur.cycles = CYC_TWO;
                        end
                        OP_IND_JUMP: begin
                            next_cur.pc_next = z_pointer;
                            next_cur.cycles = CYC_TWO;
                        end
                        OP_REL_CALL, OP_IND_CALL: begin
                            next_cur.pc_next = (op_code == OP_REL_CALL) ? pc_rel : z_pointer;
                            next_cur.push_pc = 1'b1;
                            next_cur.cycles = CYC_THREE;
                        end
                        OP_ROUTINE_EXIT, OP_IRQ_EXIT: begin
                            next_cur.pc_next = stack_pc;
                            next_cur.cycles = CYC_FOUR;
                            if (op_code == OP_IRQ_EXIT) begin
                                next_cur.flags[FL_I] = 1'b1;
                            end
                        end
                        default: begin
                            next_cur.pc_next = next_cur.pc_next;
                        end
                    endcase
                    next_cur.left = next_cur.cycles - CYC_ONE;
                    if (next_cur.cycles == CYC_ONE) begin
                        next_cur.done = 1'b1;
                    end else begin
                        next_cur.state = ST_BUSY;
                    end
                end
            end
            ST_BUSY: begin
                next_cur.left = cur.left - CYC_ONE;
                if (cur.left == CYC_ONE) begin
                    next_cur.done = 1'b1;
                    next_cur.state = ST_IDLE;
                end
            end
            default: begin
                next_cur.state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    // a new operation may only be accepted while idle
    assign op_ready = (cur.state == ST_IDLE);
    assign done = cur.done;
    assign result_lo = cur.result_lo;
    assign result_hi = cur.result_hi;
    assign write_lo = cur.write_lo;
    assign write_hi = cur.write_hi;
    assign flags_out = cur.flags;
    assign pc_next = cur.pc_next;
    assign push_pc = cur.push_pc;
    assign cycles = cur.cycles;

    property p_busy_len;
        @(posedge ref_clk) disable iff (rst)
        (op_ready && op_valid) |=> (cycles == CYC_ONE) || !op_ready;
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("multi-cycle op did not go busy");

    property p_jump_two;
        @(posedge ref_clk) disable iff (rst)
        (op_ready && op_valid && op_code == OP_REL_JUMP) |=> !op_ready ##1 done && op_ready;
    endproperty
    a_jump_two: assert property (p_jump_two) else $error("jump not two cycles");

    property p_call_three;
        @(posedge ref_clk) disable iff (rst)
        (op_ready && op_valid && op_code == OP_IND_CALL)
            |=> push_pc && pc_next == $past(z_pointer) ##2 done;
    endproperty
    a_call_three: assert property (p_call_three) else $error("call not three cycles");

    property p_ret_four;
        @(posedge ref_clk) disable iff (rst)
        (op_ready && op_valid && op_code == OP_IRQ_EXIT) |=> flags_out[FL_I] ##3 done;
    endproperty
    a_ret_four: assert property (p_ret_four) else $error("irq exit wrong");

    property p_cmp_nowrite;
        @(posedge ref_clk) disable iff (rst)
        (op_ready && op_valid && op_code == OP_CMP_REGS) |=> !write_lo && done;
    endproperty
    a_cmp_nowrite: assert property (p_cmp_nowrite) else $error("compare wrote");

    property p_add_one;
        @(posedge ref_clk) disable iff (rst)
        (op_ready && op_valid && op_code == OP_ADD)
            |=> write_lo && done && result_lo == $past(opnd_d) + $past(opnd_r);
    endproperty
    a_add_one: assert property (p_add_one) else $error("add result wrong");

    property p_logic_v;
        @(posedge ref_clk) disable iff (rst)
        (op_ready && op_valid && op_code == OP_XOR_REGS) |=> !flags_out[FL_V];
    endproperty
    a_logic_v: assert property (p_logic_v) else $error("logic op left V set");

    property p_branch_cost;
        @(posedge ref_clk) disable iff (rst)
        (op_ready && op_valid && op_code == OP_BRANCH_SET && !flag_val)
            |=> done && cycles == CYC_ONE && pc_next == $past(pc_now) + PC_STEP;
    endproperty
    a_branch_cost: assert property (p_branch_cost) else $error("untaken branch wrong");

    property p_skip_eq;
        @(posedge ref_clk) disable iff (rst)
        (op_ready && op_valid && op_code == OP_SKIP_IF_EQUAL && opnd_d == opnd_r && !next_is_long)
            |=> cycles == CYC_TWO && pc_next == $past(pc_now) + PC_SKIP1;
    endproperty
    a_skip_eq: assert property (p_skip_eq) else $error("skip if equal wrong");

endmodule

// ===== verification/abex_tb.sv
/*
 * abex_tb: self-checking bench for abex_core; each scenario issues operations,
 * then checks results and flags or the next program counter, and the cycle cost.
 * assumes: inputs change at falling edges; done marks the last cycle of a cost.
 */
`timescale 1ns/1ps
module testbench;
    import abex_pkg::*;
    logic            ref_clk = 1'b0;
    logic            rst = 1'b1;
    logic            op_valid = 1'b0;
    abex_op_t        op_code = OP_NOP;
    logic [DW-1:0]   opnd_d = 8'h00, opnd_d_high = 8'h00, opnd_r = 8'h00, io_value = 8'h00;
    logic [2:0]      bit_sel = 3'h0;
    logic [OFSW-1:0] pc_offset = 12'h000;
    logic [PCW-1:0]  pc_now = 16'h0000, z_pointer = 16'h0000, stack_pc = 16'h0000;
    logic            next_is_long = 1'b0;
    logic [7:0]      flags_in = 8'h00;
    logic            op_ready, done, write_lo, write_hi, push_pc;
    logic [DW-1:0]   result_lo, result_hi;
    logic [7:0]      flags_out;
    logic [PCW-1:0]  pc_next;
    logic [2:0]      cycles;
    int              fail_count = 0, compares = 0, n = 0, tick = 0;
    logic            wl, ph, wh, rdy;

    abex_core i_dut (.ref_clk(ref_clk), .rst(rst), .op_valid(op_valid), .op_code(op_code),
        .opnd_d(opnd_d), .opnd_d_high(opnd_d_high), .opnd_r(opnd_r), .bit_sel(bit_sel),
        .io_value(io_value), .pc_offset(pc_offset), .pc_now(pc_now), .z_pointer(z_pointer),
        .stack_pc(stack_pc), .next_is_long(next_is_long), .flags_in(flags_in),
        .op_ready(op_ready), .done(done), .result_lo(result_lo), .result_hi(result_hi),
        .write_lo(write_lo), .write_hi(write_hi), .flags_out(flags_out), .pc_next(pc_next),
        .push_pc(push_pc), .cycles(cycles));

    always #12.5 ref_clk = ~ref_clk;

    // the whole run needs under two hundred cycles; a hang stops well past that
    always @(posedge ref_clk) begin
        tick <= tick + 1;
        if (tick == 3000) begin
            fail_count++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // issue one op; n counts cycles from acceptance to the done pulse
    task automatic op(input abex_op_t c, input logic [7:0] d, input logic [7:0] r,
                      input logic [7:0] fl);
        @(negedge ref_clk);
        op_code = c;
        opnd_d = d;
        opnd_r = r;
        flags_in = fl;
        op_valid = 1'b1;
        @(negedge ref_clk);
        op_valid = 1'b0;
        wl = write_lo;
        wh = write_hi;
        ph = push_pc;
        rdy = op_ready;
        n = 1;
        while (done !== 1'b1 && n < 8) begin
            @(negedge ref_clk);
            n++;
        end
    endtask

    task automatic res(input logic [7:0] e, input logic [7:0] m, input logic [7:0] f);
        chk({8'h00, result_lo}, {8'h00, e});
        chk({8'h00, flags_out & m}, {8'h00, f});
        chk(n[15:0], 16'h0001);
    endtask

    task automatic t_arith();
        op(OP_ADD, 8'h8f, 8'h71, 8'h00); res(8'h00, 8'h2f, 8'h23); // sum carry out
        op(OP_ADC, 8'h7f, 8'h00, 8'h01); res(8'h80, 8'h2f, 8'h2c); // carry in
        op(OP_SUB, 8'h10, 8'h01, 8'h00); res(8'h0f, 8'h2f, 8'h20); // half borrow
        op(OP_DIFF_BORROW, 8'h00, 8'h00, 8'h01); res(8'hff, 8'h2f, 8'h25); // borrow
        op(OP_DIFF_IMM, 8'h80, 8'h01, 8'h00); res(8'h7f, 8'h2f, 8'h28); // overflow
        op(OP_CMP_REGS, 8'h05, 8'h05, 8'h00); res(8'h05 & 8'h00, 8'h00, 8'h00); // cost
        chk({8'h00, flags_out & 8'h2f}, 16'h0002); // equal sets zero
        chk({15'h0, wl}, 16'h0000); // no write
        op(OP_DIFF_IMM_BORROW, 8'h20, 8'h10, 8'h01); res(8'h0f, 8'h2f, 8'h20); // imm borrow
        op(OP_TWOS_COMPLEMENT, 8'h01, 8'h00, 8'h00); res(8'hff, 8'h2f, 8'h25); // negate
        op(OP_CMP_IMM, 8'h10, 8'h20, 8'h00);
        chk({8'h00, flags_out & 8'h2f}, 16'h0005); // immediate borrow
        chk({15'h0, wl}, 16'h0000); // no write
        op(OP_CMP_BORROW, 8'h05, 8'h05, 8'h01);
        chk({8'h00, flags_out & 8'h2f}, 16'h0025); // carry in
        $display("arith test done");
    endtask

    task automatic t_word();
        opnd_d_high = 8'hff;
        op(OP_ADD_WORD_IMM, 8'hff, 8'h01, 8'h00);
        chk({result_hi, result_lo}, 16'h0000); // wrap to zero
        chk({8'h00, flags_out & 8'h0f}, 16'h0003); // zero and carry
        chk(n[15:0], 16'h0002); // two cycles
        chk({14'h0, wh, wl}, 16'h0003); // both bytes written
        opnd_d_high = 8'h00;
        op(OP_WORD_MINUS_IMM, 8'h00, 8'h01, 8'h00);
        chk({result_hi, result_lo}, 16'hffff); // borrow
        chk({8'h00, flags_out & 8'h0f}, 16'h0005); // carry negative
        $display("word test done");
    endtask

    task automatic t_logic();
        op(OP_AND, 8'hf0, 8'h3c, 8'h08); res(8'h30, 8'h0e, 8'h00); // and clears V
        op(OP_XOR_REGS, 8'h5a, 8'h5a, 8'h08); res(8'h00, 8'h0e, 8'h02); // xor zero
        op(OP_AND_IMM, 8'hff, 8'h80, 8'h00); res(8'h80, 8'h0e, 8'h04); // and immediate
        op(OP_OR, 8'h12, 8'h21, 8'h0e); res(8'h33, 8'h0e, 8'h00); // or registers
        op(OP_OR_IMM, 8'h01, 8'h80, 8'h00); res(8'h81, 8'h0e, 8'h04); // or immediate
        op(OP_CLEAR_BITS_MASK, 8'hff, 8'h0f, 8'h00); res(8'hf0, 8'h0e, 8'h04); // clear
        op(OP_SET_BITS_MASK, 8'h41, 8'h80, 8'h00); res(8'hc1, 8'h0e, 8'h04); // set
        op(OP_ZERO_MINUS_TEST, 8'h80, 8'h00, 8'h08); res(8'h80, 8'h0e, 8'h04); // test
        op(OP_ZERO_REGISTER, 8'h5a, 8'h00, 8'h0c); res(8'h00, 8'h0e, 8'h02); // clear
        op(OP_INC, 8'h7f, 8'h00, 8'h21); res(8'h80, 8'h2f, 8'h2d); // keeps C and H
        op(OP_DEC, 8'h01, 8'h00, 8'h21); res(8'h00, 8'h2f, 8'h23); // to zero
        $display("logic test done");
    endtask

    task automatic pcc(input logic [15:0] pc, input int c);
        chk(pc_next, pc);
        chk(n[15:0], c[15:0]);
        chk({13'h0, cycles}, c[15:0]);
        chk({15'h0, rdy}, (c == 1) ? 16'h0001 : 16'h0000);
    endtask

    task automatic t_skip();
        pc_now = 16'h0200;
        next_is_long = 1'b1;
        op(OP_SKIP_IF_EQUAL, 8'h33, 8'h33, 8'h00); pcc(16'h0203, 3); // long skip
        op(OP_SKIP_IF_EQUAL, 8'h33, 8'h32, 8'h00); pcc(16'h0201, 1); // no skip
        next_is_long = 1'b0;
        op(OP_SKIP_IF_EQUAL, 8'h44, 8'h44, 8'h00); pcc(16'h0202, 2); // short skip
        bit_sel = 3'h2;
        op(OP_SKIP_REG_CLR, 8'hfb, 8'hfb, 8'h00); pcc(16'h0202, 2); // bit clear
        op(OP_SKIP_REG_SET, 8'hfb, 8'hfb, 8'h00); pcc(16'h0201, 1); // not set
        io_value = 8'h04;
        op(OP_SKIP_IO_SET, 8'h00, 8'h00, 8'h00); pcc(16'h0202, 2); // io set
        op(OP_SKIP_IO_CLR, 8'h00, 8'h00, 8'h00); pcc(16'h0201, 1); // io not clear
        $display("skip test done");
    endtask

    task automatic t_jump();
        pc_now = 16'h0100;
        pc_offset = 12'hffe;
        z_pointer = 16'h1234;
        stack_pc = 16'h0456;
        op(OP_REL_JUMP, 8'h00, 8'h00, 8'h00); pcc(16'h00ff, 2); // backward jump
        chk({15'h0, ph}, 16'h0000); // nothing pushed
        op(OP_IND_JUMP, 8'h00, 8'h00, 8'h00); pcc(16'h1234, 2); // pointer jump
        op(OP_REL_CALL, 8'h00, 8'h00, 8'h00); pcc(16'h00ff, 3); // relative call
        chk({15'h0, ph}, 16'h0001); // return address pushed
        op(OP_IND_CALL, 8'h00, 8'h00, 8'h00); pcc(16'h1234, 3); // pointer call
        op(OP_ROUTINE_EXIT, 8'h00, 8'h00, 8'h00); pcc(16'h0456, 4); // return
        chk({15'h0, flags_out[FL_I]}, 16'h0000); // plain return keeps I
        op(OP_IRQ_EXIT, 8'h00, 8'h00, 8'h00); pcc(16'h0456, 4); // irq return
        chk({15'h0, flags_out[FL_I]}, 16'h0001); // enable restored
        $display("jump test done");
    endtask

    // every status bit, both branch polarities, taken and not taken
    task automatic t_branch();
        pc_now = 16'h0300;
        pc_offset = 12'h010;
        for (int b = 0; b < 8; b++) begin
            bit_sel = b[2:0];
            op(OP_BRANCH_SET, 8'h00, 8'h00, 8'h01 << b); pcc(16'h0311, 2);
            op(OP_BRANCH_SET, 8'h00, 8'h00, ~(8'h01 << b)); pcc(16'h0301, 1);
            op(OP_BRANCH_CLR, 8'h00, 8'h00, ~(8'h01 << b)); pcc(16'h0311, 2);
            op(OP_BRANCH_CLR, 8'h00, 8'h00, 8'h01 << b); pcc(16'h0301, 1);
        end
        $display("branch test done");
    endtask

    initial begin
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        rst = 1'b0;
        t_arith();
        t_word();
        t_logic();
        t_skip();
        t_jump();
        t_branch();
        end_sim();
    end
endmodule
